// >>> verilog/ait_target.sv
// Notes on behaviour
// - Bus-select high enables two-wire target operation
// - Works at standard and fast SCL rates
// - Single and multi-byte reads and writes accepted
// - Strap high: answers primary address
// - Strap low: answers alternate address
`timescale 1ns/1ps
`default_nettype none
module ait_target (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Strap and select pins
    input wire logic busSelect,
    input wire logic address_strap_pin,
    // Two-wire bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    // Register space
    output ait_pkg::ait_reg_req_t regReq,
    input wire logic [7:0] regRdData
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    ait_pkg::ait_pins_t pinsRaw;
    ait_pkg::ait_pins_t pinsS;
    logic [3:0] pinsSync;

    assign pinsRaw = '{sel: busSelect, strap: address_strap_pin, scl: sclIn, sda: sdaIn};

    ait_sync #(
        .WIDTH(4),
        .RESET_VAL(ait_pkg::PINS_SYNC_RESET)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn(pinsRaw),
        .syncOut(pinsSync)
    );
    assign pinsS = ait_pkg::ait_pins_t'(pinsSync);

    // ----------------------------------------
    // State
    // ----------------------------------------
    ait_pkg::ait_state_t state_r, state_nxt;
    logic sclPrev_r, sclPrev_nxt;
    logic sdaPrev_r, sdaPrev_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [3:0] holdCnt_r, holdCnt_nxt;
    logic [7:0] shiftRx_r, shiftRx_nxt;
    logic [7:0] shiftTx_r, shiftTx_nxt;
    logic readDir_r, readDir_nxt;
    logic firstByte_r, firstByte_nxt;
    logic sdaOe_n_r, sdaOe_n_nxt;
    ait_pkg::ait_reg_req_t regReq_r, regReq_nxt;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic fallDue;
    logic [6:0] ownAddr;

    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    assign sclRise = pinsS.scl & ~sclPrev_r;
    assign sclFall = ~pinsS.scl & sclPrev_r;
    assign startCond = pinsS.scl & sclPrev_r & sdaPrev_r & ~pinsS.sda;
    assign stopCond = pinsS.scl & sclPrev_r & ~sdaPrev_r & pinsS.sda;
    // Data may only move once the hold time after SCL fall has passed
    assign fallDue = (holdCnt_r == 4'h1);
    assign ownAddr = pinsS.strap ? ait_pkg::ADDR_PRIMARY : ait_pkg::ADDR_ALTERNATE;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        sclPrev_nxt = pinsS.scl;
        sdaPrev_nxt = pinsS.sda;
        bitCnt_nxt = bitCnt_r;
        holdCnt_nxt = holdCnt_r;
        shiftRx_nxt = shiftRx_r;
        shiftTx_nxt = shiftTx_r;
        readDir_nxt = readDir_r;
        firstByte_nxt = firstByte_r;
        sdaOe_n_nxt = sdaOe_n_r;
        regReq_nxt = regReq_r;
        regReq_nxt.wrEn = 1'b0;
        regReq_nxt.rdEn = 1'b0;

        if (holdCnt_r != 4'h0) begin
            holdCnt_nxt = holdCnt_r - 4'h1;
        end
        if (sclFall) begin
            holdCnt_nxt = ait_pkg::HOLD_CNT_INIT;
        end
        if (regReq_r.wrEn || regReq_r.rdEn) begin
            regReq_nxt.addr = regReq_r.addr + 8'h01;
        end
        if (sclRise && (state_r == ait_pkg::AIT_ADDR || state_r == ait_pkg::AIT_WR_BYTE ||
                state_r == ait_pkg::AIT_RD_BYTE)) begin
            bitCnt_nxt = bitCnt_r + 4'h1;
            shiftRx_nxt = {shiftRx_r[6:0], pinsS.sda};
        end

        case (state_r)
            ait_pkg::AIT_IDLE: begin
            end
            ait_pkg::AIT_ADDR: begin
                if (fallDue && bitCnt_r == ait_pkg::BITS_PER_BYTE) begin
                    if (shiftRx_r[7:1] == ownAddr) begin
                        state_nxt = ait_pkg::AIT_ADDR_ACK;
                        sdaOe_n_nxt = 1'b0;
                        readDir_nxt = shiftRx_r[0];
                        regReq_nxt.rdEn = shiftRx_r[0];
                    end else begin
                        state_nxt = ait_pkg::AIT_IDLE;
                    end
                end
            end
            ait_pkg::AIT_ADDR_ACK: begin
                if (fallDue) begin
                    bitCnt_nxt = 4'h0;
                    if (readDir_r) begin
                        state_nxt = ait_pkg::AIT_RD_BYTE;
                        sdaOe_n_nxt = regRdData[7];
                        shiftTx_nxt = {regRdData[6:0], 1'b1};
                    end else begin
                        state_nxt = ait_pkg::AIT_WR_BYTE;
                        sdaOe_n_nxt = 1'b1;
                    end
                end
            end
            ait_pkg::AIT_WR_BYTE: begin
                if (fallDue && bitCnt_r == ait_pkg::BITS_PER_BYTE) begin
                    state_nxt = ait_pkg::AIT_WR_ACK;
                    sdaOe_n_nxt = 1'b0;
                    firstByte_nxt = 1'b0;
                    if (firstByte_r) begin
                        regReq_nxt.addr = shiftRx_r;
                    end else begin
                        regReq_nxt.wrData = shiftRx_r;
                        regReq_nxt.wrEn = 1'b1;
                    end
                end
            end
            ait_pkg::AIT_WR_ACK: begin
                if (fallDue) begin
                    state_nxt = ait_pkg::AIT_WR_BYTE;
                    sdaOe_n_nxt = 1'b1;
                    bitCnt_nxt = 4'h0;
                end
            end
            ait_pkg::AIT_RD_BYTE: begin
                if (fallDue) begin
                    if (bitCnt_r == ait_pkg::BITS_PER_BYTE) begin
                        state_nxt = ait_pkg::AIT_RD_ACK;
                        sdaOe_n_nxt = 1'b1;
                        bitCnt_nxt = 4'h0;
                    end else begin
                        sdaOe_n_nxt = shiftTx_r[7];
                        shiftTx_nxt = {shiftTx_r[6:0], 1'b1};
                    end
                end
            end
            ait_pkg::AIT_RD_ACK: begin
                if (sclRise) begin
                    if (pinsS.sda) begin
                        // Controller said no more; wait for stop or restart
                        state_nxt = ait_pkg::AIT_IDLE;
                    end else begin
                        regReq_nxt.rdEn = 1'b1;
                    end
                end
                if (fallDue) begin
                    state_nxt = ait_pkg::AIT_RD_BYTE;
                    sdaOe_n_nxt = regRdData[7];
                    shiftTx_nxt = {regRdData[6:0], 1'b1};
                end
            end
            default: begin
                state_nxt = ait_pkg::AIT_IDLE;
                sdaOe_n_nxt = 1'b1;
            end
        endcase

        // Restart keeps the pointer so a read can follow a pointer write
        if (startCond) begin
            state_nxt = ait_pkg::AIT_ADDR;
            bitCnt_nxt = 4'h0;
            holdCnt_nxt = 4'h0;
            firstByte_nxt = 1'b1;
            sdaOe_n_nxt = 1'b1;
        end
        if (stopCond || !pinsS.sel) begin
            state_nxt = ait_pkg::AIT_IDLE;
            sdaOe_n_nxt = 1'b1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ait_pkg::AIT_IDLE;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
            bitCnt_r <= 4'h0;
            holdCnt_r <= 4'h0;
            shiftRx_r <= 8'h00;
            shiftTx_r <= 8'hFF;
            readDir_r <= 1'b0;
            firstByte_r <= 1'b1;
            sdaOe_n_r <= 1'b1;
            regReq_r <= '{addr: ait_pkg::PTR_RESET, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b0};
            sdaOut <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sclPrev_r <= sclPrev_nxt;
            sdaPrev_r <= sdaPrev_nxt;
            bitCnt_r <= bitCnt_nxt;
            holdCnt_r <= holdCnt_nxt;
            shiftRx_r <= shiftRx_nxt;
            shiftTx_r <= shiftTx_nxt;
            readDir_r <= readDir_nxt;
            firstByte_r <= firstByte_nxt;
            sdaOe_n_r <= sdaOe_n_nxt;
            regReq_r <= regReq_nxt;
            sdaOut <= 1'b0;
        end
    end

    assign sdaOe_n = sdaOe_n_r;
    assign regReq = regReq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_sel_release;
        !pinsS.sel |=> sdaOe_n_r && state_r == ait_pkg::AIT_IDLE;
    endproperty
    a_sel_release: assert property (p_sel_release) else $error("sda driven while deselected");

    property p_hold_after_fall;
        sclFall |=> $stable(sdaOe_n_r) [*8];
    endproperty
    a_hold_after_fall: assert property (p_hold_after_fall) else $error("sda moved in hold");

    property p_change_scl_low;
        $changed(sdaOe_n_r) && $past(pinsS.sel) && !$past(stopCond) |-> !$past(pinsS.scl);
    endproperty
    a_change_scl_low: assert property (p_change_scl_low) else $error("sda moved, scl high");

    property p_ack_primary;
        state_r == ait_pkg::AIT_ADDR && fallDue && bitCnt_r == ait_pkg::BITS_PER_BYTE &&
            pinsS.strap && pinsS.sel && !startCond && !stopCond &&
            shiftRx_r[7:1] == ait_pkg::ADDR_PRIMARY
        |=> state_r == ait_pkg::AIT_ADDR_ACK && !sdaOe_n_r;
    endproperty
    a_ack_primary: assert property (p_ack_primary) else $error("primary not acked");

    property p_ack_alternate;
        state_r == ait_pkg::AIT_ADDR && fallDue && bitCnt_r == ait_pkg::BITS_PER_BYTE &&
            !pinsS.strap && pinsS.sel && !startCond && !stopCond
        |=> (state_r == ait_pkg::AIT_ADDR_ACK) ==
            ($past(shiftRx_r[7:1]) == ait_pkg::ADDR_ALTERNATE);
    endproperty
    a_ack_alternate: assert property (p_ack_alternate) else $error("alternate mismatch");

    property p_ptr_advance;
        (regReq_r.wrEn || regReq_r.rdEn) && state_r != ait_pkg::AIT_WR_BYTE
        |=> regReq_r.addr == $past(regReq_r.addr) + 8'h01;
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) else $error("pointer not advanced");

    property p_next_write_byte;
        state_r == ait_pkg::AIT_WR_ACK && fallDue && pinsS.sel && !startCond && !stopCond
        |=> state_r == ait_pkg::AIT_WR_BYTE && bitCnt_r == 4'h0 && sdaOe_n_r;
    endproperty
    a_next_write_byte: assert property (p_next_write_byte) else $error("no next byte");

endmodule : ait_target
`default_nettype wire

// >>> common/ait_pkg.sv
// ----------------------------------------
// Two-wire target port constants and types
// ----------------------------------------
package ait_pkg;

    // ----------------------------------------
    // Target addresses
    // ----------------------------------------
    localparam logic [6:0] ADDR_PRIMARY = 7'h1D;
    localparam logic [6:0] ADDR_ALTERNATE = 7'h53;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int STD_SCL_KHZ = 100;
    localparam int FAST_SCL_KHZ = 400;
    localparam int SDA_HOLD_NS = 300;
    localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOLD_CNT_INIT = 4'(SDA_HOLD_CYC);

    // ----------------------------------------
    // Byte framing and reset values
    // ----------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] PINS_SYNC_RESET = 4'hF;

    typedef enum logic [2:0] {
        AIT_IDLE = 3'b000,
        AIT_ADDR = 3'b001,
        AIT_ADDR_ACK = 3'b010,
        AIT_WR_BYTE = 3'b011,
        AIT_WR_ACK = 3'b100,
        AIT_RD_BYTE = 3'b101,
        AIT_RD_ACK = 3'b110
    } ait_state_t;

    typedef struct packed {
        logic sel;
        logic strap;
        logic scl;
        logic sda;
    } ait_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrEn;
        logic rdEn;
    } ait_reg_req_t;

endpackage : ait_pkg

// >>> verilog/ait_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ait_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1_r;
            logic stage2_r;
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1_r <= RESET_VAL[i];
                    stage2_r <= RESET_VAL[i];
                end else begin
                    stage1_r <= asyncIn[i];
                    stage2_r <= stage1_r;
                end
            end
            assign syncOut[i] = stage2_r;
        end
    endgenerate

endmodule : ait_sync
`default_nettype wire

// >>> verif/ait_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-wire bus controller model
// ----------------------------------------
module ait_host_model (
    // Clock
    input wire logic clock,
    // Bus, SDA released means pulled high
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaRel
);
    // Quarter bit time in clocks; each test sets it for its bus rate
    int qCyc = 17;

    initial begin
        sclOut = 1'b1;
        sdaRel = 1'b1;
    end

    task automatic tick();
        repeat (qCyc) @(posedge clock);
        #1;
    endtask : tick

    // Also serves as restart from SCL low
    task automatic start_cond();
        sdaRel = 1'b1;
        tick();
        sclOut = 1'b1;
        tick();
        sdaRel = 1'b0;
        tick();
        sclOut = 1'b0;
        tick();
    endtask : start_cond

    task automatic stop_cond();
        sdaRel = 1'b0;
        tick();
        sclOut = 1'b1;
        tick();
        sdaRel = 1'b1;
        tick();
        tick();
    endtask : stop_cond

    // Data moves mid-low, sampled mid-high
    task automatic bit_cycle(input logic b, output logic got);
        sdaRel = b;
        tick();
        sclOut = 1'b1;
        tick();
        got = sdaLine;
        tick();
        sclOut = 1'b0;
        tick();
    endtask : bit_cycle

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], x);
        end
        bit_cycle(1'b1, x);
        ack = ~x;
    endtask : send_byte

    // Refusing the last byte ends a read
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(last, x);
    endtask : recv_byte
endmodule : ait_host_model
`default_nettype wire

// >>> verif/test_accel_i2c_target_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_accel_i2c_target_port;
    logic clock;
    logic sys_rst;
    logic busSelect;
    logic strap;
    logic sclLine;
    logic hostRel;
    logic sdaOut;
    logic sdaOe_n;
    logic sdaLine;
    ait_pkg::ait_reg_req_t regReq;
    logic [7:0] regRdData;
    logic [7:0] regMem [256];
    logic [7:0] q [$];
    logic a;
    int fail_count = 0;
    int num_checks = 0;

    // Open drain with pull-up
    assign sdaLine = hostRel & (sdaOe_n | sdaOut);

    ait_target DUT (.clock(clock), .sys_rst(sys_rst), .busSelect(busSelect),
        .address_strap_pin(strap), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .regReq(regReq), .regRdData(regRdData));

    ait_host_model host (.clock(clock), .sdaLine(sdaLine), .sclOut(sclLine), .sdaRel(hostRel));

    // ----------------------------------------
    // Register space behind the port
    // ----------------------------------------
    always @(posedge clock) begin
        if (regReq.wrEn === 1'b1) regMem[regReq.addr] <= regReq.wrData;
        if (regReq.rdEn === 1'b1) regRdData <= regMem[regReq.addr];
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic write_seq(input logic [7:0] aw, input logic [7:0] ptr, input logic [7:0] d [$]);
        host.start_cond();
        host.send_byte(aw, a);
        check("address ack", 8'h01, {7'h00, a});
        host.send_byte(ptr, a);
        check("pointer ack", 8'h01, {7'h00, a});
        foreach (d[i]) begin
            host.send_byte(d[i], a);
            check("data ack", 8'h01, {7'h00, a});
        end
        host.stop_cond();
    endtask : write_seq

    task automatic read_seq(input logic [7:0] aw, input logic [7:0] ptr, input int n,
            input logic viaStop);
        logic [7:0] b;
        q = {};
        host.start_cond();
        host.send_byte(aw, a);
        host.send_byte(ptr, a);
        // Stop then fresh start must keep the pointer just like a restart
        if (viaStop) host.stop_cond();
        host.start_cond();
        host.send_byte(aw | 8'h01, a);
        check("read address ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) begin
            host.recv_byte(i == n - 1, b);
            q.push_back(b);
        end
        host.stop_cond();
    endtask : read_seq

    // Burst across the pointer wrap at fast speed
    task automatic test_fast_burst();
        host.qCyc = 17;
        strap = 1'b1;
        write_seq(8'h3A, 8'hFE, {8'h11, 8'h22, 8'h33});
        check("reg FE", 8'h11, regMem[8'hFE]);
        check("reg FF", 8'h22, regMem[8'hFF]);
        check("reg 00", 8'h33, regMem[8'h00]);
        read_seq(8'h3A, 8'hFE, 3, 1'b0);
        check("read 0", 8'h11, q[0]);
        check("read 1", 8'h22, q[1]);
        check("read 2", 8'h33, q[2]);
        check("pointer after read", 8'h01, regReq.addr);
        $display("test fast_burst done");
    endtask : test_fast_burst

    // Single bytes on the alternate address at standard speed
    task automatic test_std_alt();
        host.qCyc = 63;
        strap = 1'b0;
        host.start_cond();
        host.send_byte(8'h3A, a);
        check("primary ignored", 8'h00, {7'h00, a});
        host.stop_cond();
        write_seq(8'hA6, 8'h40, {8'h5C});
        check("reg 40", 8'h5C, regMem[8'h40]);
        read_seq(8'hA6, 8'h40, 1, 1'b1);
        check("single read", 8'h5C, q[0]);
        $display("test std_alt done");
    endtask : test_std_alt

    // Reset in mid-run, then a read from the reset pointer with no pointer write
    task automatic test_mid_reset();
        logic [7:0] b;
        host.qCyc = 17;
        sys_rst = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("pointer after reset", 8'h00, regReq.addr);
        check("sda after reset", 8'h01, {7'h00, sdaOe_n});
        host.start_cond();
        host.send_byte(8'hA7, a);
        check("reset read ack", 8'h01, {7'h00, a});
        host.recv_byte(1'b1, b);
        host.stop_cond();
        check("read at reset pointer", 8'h33, b);
        check("pointer after one read", 8'h01, regReq.addr);
        $display("test mid_reset done");
    endtask : test_mid_reset

    // Select low keeps the port off the bus
    task automatic test_deselect();
        host.qCyc = 17;
        busSelect = 1'b0;
        host.start_cond();
        host.send_byte(8'hA6, a);
        check("deselected ack", 8'h00, {7'h00, a});
        host.stop_cond();
        check("sda released", 8'h01, {7'h00, sdaOe_n});
        busSelect = 1'b1;
        $display("test deselect done");
    endtask : test_deselect

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        $display("CHECK FAILED run length expected end seen limit");
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        busSelect = 1'b1;
        strap = 1'b1;
        regRdData = 8'h00;
        for (int i = 0; i < 256; i++) regMem[i] = 8'(i) ^ 8'h3C;
        repeat (5) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("reset sda", 8'h01, {7'h00, sdaOe_n});
        check("reset pointer", 8'h00, regReq.addr);
        test_fast_burst();
        test_std_alt();
        test_mid_reset();
        test_deselect();
        finish_test();
    end
endmodule : test_accel_i2c_target_port
`default_nettype wire
